// ==== design/iolcs_pkg.sv ====
// shared constants, types and decode functions for the i/o line config and sampling block
package iolcs_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int LED_UNIT_MS = 10;
  localparam int SIGNAL_STRENGTH_PWM_UNIT_MS = 100;
  localparam int LED_PERIOD_COORD_MS = 500;
  localparam int LED_PERIOD_NODE_MS = 250;

  localparam logic [7:0] OFS_PULL_EN = 8'h00;
  localparam logic [7:0] OFS_PULL_DIR = 8'h04;
  localparam logic [7:0] OFS_PWM_A = 8'h08;
  localparam logic [7:0] OFS_PWM_B = 8'h0c;
  localparam logic [7:0] OFS_LED_TIME = 8'h10;
  localparam logic [7:0] OFS_SIGNAL_STRENGTH_PWM_TMR = 8'h14;
  localparam logic [7:0] OFS_AREF = 8'h18;
  localparam logic [7:0] OFS_CHG_MASK = 8'h1c;
  localparam logic [7:0] OFS_SLEEP_RATE = 8'h20;
  localparam logic [7:0] OFS_INTERVAL = 8'h24;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [7:0] OFS_FORCE = 8'h2c;
  localparam logic [7:0] OFS_TEMP = 8'h30;
  localparam logic [7:0] OFS_SUPPLY = 8'h34;

  localparam int CTRL_API_BIT = 0;
  localparam int CTRL_COORD_BIT = 1;

  localparam logic [14:0] RST_PULL_EN = 15'h7fff;
  localparam logic [14:0] RST_PULL_DIR = 15'h0000;
  localparam logic [9:0] RST_DUTY = 10'h000;
  localparam logic [7:0] RST_LED_TIME = 8'h00;
  localparam logic [7:0] RST_SIGNAL_STRENGTH_PWM_TMR = 8'h28;
  localparam logic [7:0] SIGNAL_STRENGTH_PWM_ALWAYS = 8'hff;
  localparam logic [15:0] RST_CHG_MASK = 16'h0000;
  localparam logic [7:0] RST_SLEEP_RATE = 8'h01;
  localparam logic [15:0] RST_INTERVAL = 16'h0000;
  localparam logic [1:0] RST_CTRL = 2'h0;

  localparam logic [2:0] FUNC_DISABLED = 3'h0;
  localparam logic [2:0] FUNC_ALT = 3'h1;
  localparam logic [2:0] FUNC_ADC = 3'h2;
  localparam logic [2:0] FUNC_DIN = 3'h3;
  localparam logic [2:0] FUNC_DOUT_LO = 3'h4;
  localparam logic [2:0] FUNC_DOUT_HI = 3'h5;

  typedef struct packed {
    logic ascii;
    logic [12:0] dio;
    logic [12:0] dio_mask;
    logic [3:0] adc_mask;
  } iolcs_sample_type;

  function automatic logic is_digital(input logic [2:0] f);
    return (f == FUNC_DIN) || (f == FUNC_DOUT_LO) || (f == FUNC_DOUT_HI);
  endfunction : is_digital

  function automatic logic pull_allowed(input logic [2:0] f);
    return (f == FUNC_DIN) || (f == FUNC_DISABLED);
  endfunction : pull_allowed

  // pull field bit to dio line number
  function automatic logic [3:0] pull_line(input int b);
    case (b)
      0: return 4'h4;
      1: return 4'h3;
      2: return 4'h2;
      3: return 4'h1;
      4: return 4'h0;
      5: return 4'h6;
      6: return 4'h8;
      7: return 4'he;
      8: return 4'h5;
      9: return 4'h9;
      10: return 4'hc;
      11: return 4'ha;
      12: return 4'hb;
      13: return 4'h7;
      default: return 4'hd;
    endcase
  endfunction : pull_line
endpackage : iolcs_pkg

// ==== design/iolcs_pwm.sv ====
// ten-bit pwm generator: high for duty/1024 of each period
module iolcs_pwm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [9:0] duty,
  output logic pwm_out
);
  logic [9:0] phase_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 10'h000;
    end else begin
      phase_reg <= phase_reg + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= enable && (phase_reg < duty);
    end
  end
endmodule : iolcs_pwm

// ==== design/iolcs_top.sv ====
// i/o line pull, pwm, led, signal_strength_pwm and sampling control with apb registers
module iolcs_top #(
  parameter int MS_CYCLES = iolcs_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0][2:0] line_func,
  input wire logic [12:0] dio_pin,
  input wire logic wake_cycle_start,
  input wire logic signal_strength_pwm_restart,
  input wire logic [9:0] signal_strength_pwm_level,
  input wire logic [7:0] board_temp,
  input wire logic [15:0] supply_mv,
  output logic [14:0] pull_en,
  output logic [14:0] pull_up,
  output logic pwm_a_out,
  output logic pwm_b_out,
  output logic signal_strength_pwm,
  output logic assoc_led,
  output logic analog_ref_hi,
  output logic change_pulse,
  output logic host_ok,
  output logic sample_valid,
  output iolcs_pkg::iolcs_sample_type sample_info
);
  // half periods kept in ms: a 10 ms unit would truncate the 125 ms node half
  localparam int LED_COORD_HALF = iolcs_pkg::LED_PERIOD_COORD_MS / 2;
  localparam int LED_NODE_HALF = iolcs_pkg::LED_PERIOD_NODE_MS / 2;
  localparam int SIGNAL_STRENGTH_PWM_RST_MS = 40 * iolcs_pkg::SIGNAL_STRENGTH_PWM_UNIT_MS;

  logic [14:0] pull_en_reg;
  logic [14:0] pull_dir_reg;
  logic [9:0] pwm_a_duty;
  logic [9:0] pwm_b_duty;
  logic [7:0] led_blink_time;
  logic [7:0] signal_strength_pwm_pwm_timer;
  logic analog_ref_select;
  logic [15:0] change_detect_mask;
  logic [7:0] sleep_rate_reg;
  logic [15:0] sample_interval;
  logic [1:0] ctrl_reg;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rdata_next;

  // apb: one wait-free access phase, read data latched during setup
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = penable;

  always_comb begin
    mapped = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr)
      iolcs_pkg::OFS_PULL_EN: rdata_next = {17'h00000, pull_en_reg};
      iolcs_pkg::OFS_PULL_DIR: rdata_next = {17'h00000, pull_dir_reg};
      iolcs_pkg::OFS_PWM_A: rdata_next = {22'h000000, pwm_a_duty};
      iolcs_pkg::OFS_PWM_B: rdata_next = {22'h000000, pwm_b_duty};
      iolcs_pkg::OFS_LED_TIME: rdata_next = {24'h000000, led_blink_time};
      iolcs_pkg::OFS_SIGNAL_STRENGTH_PWM_TMR: rdata_next = {24'h000000, signal_strength_pwm_pwm_timer};
      iolcs_pkg::OFS_AREF: rdata_next = {31'h00000000, analog_ref_select};
      iolcs_pkg::OFS_CHG_MASK: rdata_next = {16'h0000, change_detect_mask};
      iolcs_pkg::OFS_SLEEP_RATE: rdata_next = {24'h000000, sleep_rate_reg};
      iolcs_pkg::OFS_INTERVAL: rdata_next = {16'h0000, sample_interval};
      iolcs_pkg::OFS_CTRL: rdata_next = {30'h00000000, ctrl_reg};
      iolcs_pkg::OFS_FORCE: rdata_next = 32'h0000_0000;
      iolcs_pkg::OFS_TEMP: rdata_next = {{24{board_temp[7]}}, board_temp};
      iolcs_pkg::OFS_SUPPLY: rdata_next = {16'h0000, supply_mv};
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = penable && psel && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rdata_next;
    end
  end

  // readback offsets ignore writes silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_en_reg <= iolcs_pkg::RST_PULL_EN;
      pull_dir_reg <= iolcs_pkg::RST_PULL_DIR;
      pwm_a_duty <= iolcs_pkg::RST_DUTY;
      pwm_b_duty <= iolcs_pkg::RST_DUTY;
      led_blink_time <= iolcs_pkg::RST_LED_TIME;
      signal_strength_pwm_pwm_timer <= iolcs_pkg::RST_SIGNAL_STRENGTH_PWM_TMR;
      analog_ref_select <= 1'b0;
      change_detect_mask <= iolcs_pkg::RST_CHG_MASK;
      sleep_rate_reg <= iolcs_pkg::RST_SLEEP_RATE;
      sample_interval <= iolcs_pkg::RST_INTERVAL;
      ctrl_reg <= iolcs_pkg::RST_CTRL;
    end else if (wr_en) begin
      case (paddr)
        iolcs_pkg::OFS_PULL_EN: pull_en_reg <= pwdata[14:0];
        iolcs_pkg::OFS_PULL_DIR: pull_dir_reg <= pwdata[14:0];
        iolcs_pkg::OFS_PWM_A: pwm_a_duty <= pwdata[9:0];
        iolcs_pkg::OFS_PWM_B: pwm_b_duty <= pwdata[9:0];
        iolcs_pkg::OFS_LED_TIME: led_blink_time <= pwdata[7:0];
        iolcs_pkg::OFS_SIGNAL_STRENGTH_PWM_TMR: signal_strength_pwm_pwm_timer <= pwdata[7:0];
        iolcs_pkg::OFS_AREF: analog_ref_select <= pwdata[0];
        iolcs_pkg::OFS_CHG_MASK: change_detect_mask <= pwdata[15:0];
        iolcs_pkg::OFS_SLEEP_RATE: sleep_rate_reg <= pwdata[7:0];
        iolcs_pkg::OFS_INTERVAL: sample_interval <= pwdata[15:0];
        iolcs_pkg::OFS_CTRL: ctrl_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  assign analog_ref_hi = analog_ref_select;

  // pull resistors, gated by the mapped line's function
  for (genvar b = 0; b < 15; b++) begin : g_pull
    logic gate;
    assign gate = iolcs_pkg::pull_allowed(line_func[iolcs_pkg::pull_line(b)]);
    assign pull_en[b] = gate && pull_en_reg[b];
    assign pull_up[b] = gate && pull_en_reg[b] && pull_dir_reg[b];
  end

  a_pull_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !iolcs_pkg::pull_allowed(line_func[4]) |-> !pull_en[0] && !pull_up[0])
    else $error("pull active on a line that is not input or disabled");
  a_pull_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> pull_en_reg == 15'h7fff && pull_dir_reg == 15'h0000)
    else $error("pull fields not at reset value");

  // millisecond tick
  logic [16:0] ms_div_reg;
  logic ms_tick;
  assign ms_tick = (ms_div_reg == 17'(MS_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_reg <= 17'h00000;
    end else begin
      ms_div_reg <= ms_tick ? 17'h00000 : ms_div_reg + 17'h00001;
    end
  end

  // pwm lines, enabled when line code selects pwm
  logic a_is_pwm;
  logic a_is_signal_strength_pwm;
  logic b_is_pwm;
  logic signal_strength_pwm_active;
  logic signal_strength_pwm_wave;
  assign a_is_pwm = line_func[10] == iolcs_pkg::FUNC_ADC;
  assign a_is_signal_strength_pwm = line_func[10] == iolcs_pkg::FUNC_ALT;
  assign b_is_pwm = line_func[11] == iolcs_pkg::FUNC_ADC;

  iolcs_pwm u_pwm_a (
    .pclk(pclk),
    .presetn(presetn),
    .enable(a_is_pwm),
    .duty(pwm_a_duty),
    .pwm_out(pwm_a_out)
  );

  iolcs_pwm u_pwm_b (
    .pclk(pclk),
    .presetn(presetn),
    .enable(b_is_pwm),
    .duty(pwm_b_duty),
    .pwm_out(pwm_b_out)
  );

  iolcs_pwm u_pwm_signal_strength_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .enable(a_is_signal_strength_pwm && signal_strength_pwm_active),
    .duty(signal_strength_pwm_level),
    .pwm_out(signal_strength_pwm_wave)
  );
  assign signal_strength_pwm = signal_strength_pwm_wave;

  a_pwm_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_a_duty == 10'h000 && $stable(pwm_a_duty) |=> !pwm_a_out)
    else $error("pwm a high with zero duty");
  a_pwm_b_off: assert property (@(posedge pclk) disable iff (!presetn)
    !b_is_pwm |=> !pwm_b_out)
    else $error("pwm b active while line not in pwm mode");

  // signal_strength_pwm hold timer in ms, restarted by each new signal reading
  logic [14:0] signal_strength_pwm_ms_reg;
  assign signal_strength_pwm_active = (signal_strength_pwm_pwm_timer == iolcs_pkg::SIGNAL_STRENGTH_PWM_ALWAYS) || (signal_strength_pwm_ms_reg != 15'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_strength_pwm_ms_reg <= 15'(SIGNAL_STRENGTH_PWM_RST_MS);
    end else if (signal_strength_pwm_restart) begin
      signal_strength_pwm_ms_reg <= 15'(signal_strength_pwm_pwm_timer * iolcs_pkg::SIGNAL_STRENGTH_PWM_UNIT_MS);
    end else if (ms_tick && signal_strength_pwm_ms_reg != 15'h0000) begin
      signal_strength_pwm_ms_reg <= signal_strength_pwm_ms_reg - 15'h0001;
    end
  end

  a_signal_strength_pwm_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    signal_strength_pwm_pwm_timer != 8'hff && signal_strength_pwm_ms_reg == 15'h0000 |=> !signal_strength_pwm)
    else $error("signal_strength_pwm output still driven after its timer ran out");

  // association led: steady blink, no network gating
  logic led_en;
  logic [11:0] led_ms_reg;
  logic [11:0] led_half_ms;
  assign led_en = line_func[5] == iolcs_pkg::FUNC_ALT;

  always_comb begin
    if (led_blink_time == 8'h00) begin
      led_half_ms = ctrl_reg[iolcs_pkg::CTRL_COORD_BIT]
        ? 12'(LED_COORD_HALF)
        : 12'(LED_NODE_HALF);
    end else begin
      led_half_ms = 12'(led_blink_time * iolcs_pkg::LED_UNIT_MS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ms_reg <= 12'h000;
      assoc_led <= 1'b0;
    end else if (!led_en) begin
      led_ms_reg <= 12'h000;
      assoc_led <= 1'b0;
    end else if (ms_tick) begin
      if (led_ms_reg + 12'h001 >= led_half_ms) begin
        led_ms_reg <= 12'h000;
        assoc_led <= !assoc_led;
      end else begin
        led_ms_reg <= led_ms_reg + 12'h001;
      end
    end
  end

  a_led_off: assert property (@(posedge pclk) disable iff (!presetn)
    !led_en |=> !assoc_led)
    else $error("association led lit while function off");

  // digital inputs: two-flop synchroniser, then previous-cycle copy
  logic [12:0] dio_meta_reg;
  logic [12:0] dio_sync_reg;
  logic [12:0] dio_prev_reg;
  logic [12:0] dig_mask;
  logic [3:0] adc_mask;
  logic any_io;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dio_meta_reg <= 13'h0000;
      dio_sync_reg <= 13'h0000;
      dio_prev_reg <= 13'h0000;
    end else begin
      dio_meta_reg <= dio_pin;
      dio_sync_reg <= dio_meta_reg;
      dio_prev_reg <= dio_sync_reg;
    end
  end

  for (genvar n = 0; n < 13; n++) begin : g_dig
    assign dig_mask[n] = iolcs_pkg::is_digital(line_func[n]);
  end
  for (genvar n = 0; n < 4; n++) begin : g_adc
    assign adc_mask[n] = line_func[n] == iolcs_pkg::FUNC_ADC;
  end
  assign any_io = (|dig_mask) || (|adc_mask);

  logic chg_hit;
  assign chg_hit = |((dio_sync_reg ^ dio_prev_reg) & change_detect_mask[12:0] & dig_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_pulse <= 1'b0;
    end else begin
      change_pulse <= chg_hit;
    end
  end

  a_chg_cause: assert property (@(posedge pclk) disable iff (!presetn)
    chg_hit |=> change_pulse ##1 sample_valid)
    else $error("monitored change did not pulse and sample");

  // wake cycle decimation: window open on every nth wake
  logic [7:0] wake_cnt_reg;
  logic window;
  assign window = wake_cnt_reg == 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_reg <= 8'h00;
    end else if (wake_cycle_start) begin
      if (wake_cnt_reg + 8'h01 >= sleep_rate_reg) begin
        wake_cnt_reg <= 8'h00;
      end else begin
        wake_cnt_reg <= wake_cnt_reg + 8'h01;
      end
    end
  end

  // periodic sample interval in ms
  logic [15:0] ivl_ms_reg;
  logic per_run;
  logic per_hit;
  assign per_run = (sample_interval != 16'h0000) && any_io && window;
  assign per_hit = per_run && ms_tick && (ivl_ms_reg + 16'h0001 >= sample_interval);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ivl_ms_reg <= 16'h0000;
    end else if (!per_run || per_hit) begin
      ivl_ms_reg <= 16'h0000;
    end else if (ms_tick) begin
      ivl_ms_reg <= ivl_ms_reg + 16'h0001;
    end
  end

  // force sample: ok first in api mode, data the cycle after
  logic force_wr;
  logic force_reg;
  logic api_mode;
  logic fire;
  assign force_wr = wr_en && paddr == iolcs_pkg::OFS_FORCE;
  assign api_mode = ctrl_reg[iolcs_pkg::CTRL_API_BIT];
  assign fire = force_reg || per_hit || change_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_reg <= 1'b0;
      host_ok <= 1'b0;
    end else begin
      force_reg <= force_wr;
      host_ok <= force_wr && api_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      sample_info <= '0;
    end else begin
      sample_valid <= fire;
      if (fire) begin
        sample_info.ascii <= force_reg && !api_mode;
        sample_info.dio <= dio_sync_reg & dig_mask;
        sample_info.dio_mask <= dig_mask;
        sample_info.adc_mask <= adc_mask;
      end
    end
  end

  sequence s_ok_then_data;
    host_ok ##1 (sample_valid && !sample_info.ascii);
  endsequence

  sequence s_ascii_data;
    !host_ok ##1 (sample_valid && sample_info.ascii);
  endsequence

  a_force_api: assert property (@(posedge pclk) disable iff (!presetn)
    force_wr && api_mode |=> s_ok_then_data)
    else $error("api force did not give ok then api frame");
  a_force_ascii: assert property (@(posedge pclk) disable iff (!presetn)
    force_wr && !api_mode |=> s_ascii_data)
    else $error("transparent force did not give ascii reply");

  a_ivl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    sample_interval == 16'h0000 && !force_reg && !change_pulse |=> !sample_valid)
    else $error("periodic sample with interval zero");
  a_no_io: assert property (@(posedge pclk) disable iff (!presetn)
    !any_io && !force_reg && !change_pulse |=> !sample_valid)
    else $error("periodic sample with no i/o line enabled");
  a_wake_window: assert property (@(posedge pclk) disable iff (!presetn)
    !window && !force_reg && !change_pulse |=> !sample_valid)
    else $error("periodic sample outside a selected wake cycle");
endmodule : iolcs_top

// ==== dv/iolcs_host_model.sv ====
// host-side apb master model issuing configuration accesses
module iolcs_host_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one transfer; waits for pready, no assumed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data flips so stale values never look valid
    pwdata <= ~d;
  endtask : xfer
endmodule : iolcs_host_model

// ==== dv/iolcs_top_tb_top.sv ====
// self-checking bench for the i/o line config and sampling block
module iolcs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // short millisecond keeps led and sampling runs brief
  localparam int MSC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [14:0][2:0] line_func = {15{iolcs_pkg::FUNC_DIN}};
  logic [12:0] dio_pin = 13'h0a5a;
  logic wake_cycle_start = 1'b0;
  logic signal_strength_pwm_restart = 1'b0;
  logic [7:0] board_temp = 8'hf6;
  logic [15:0] supply_mv = 16'h0ce4;
  logic [14:0] pull_en, pull_up;
  logic pwm_a_out, pwm_b_out, signal_strength_pwm, assoc_led, analog_ref_hi;
  logic change_pulse, host_ok, sample_valid;
  iolcs_pkg::iolcs_sample_type sample_info;
  int fail_count = 0;
  int checks_done = 0;

  always #4 pclk = ~pclk;

  iolcs_host_model iolcs_host_model_inst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  iolcs_top #(.MS_CYCLES(MSC)) iolcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_func(line_func), .dio_pin(dio_pin),
    .wake_cycle_start(wake_cycle_start), .signal_strength_pwm_restart(signal_strength_pwm_restart), .signal_strength_pwm_level(10'h200),
    .board_temp(board_temp), .supply_mv(supply_mv), .pull_en(pull_en), .pull_up(pull_up),
    .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out), .signal_strength_pwm(signal_strength_pwm),
    .assoc_led(assoc_led), .analog_ref_hi(analog_ref_hi), .change_pulse(change_pulse),
    .host_ok(host_ok), .sample_valid(sample_valid), .sample_info(sample_info));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    iolcs_host_model_inst.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    iolcs_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
    chk({n, "_err"}, {31'h0, a == 8'h3c}, {31'h0, e});
  endtask : rd

  task automatic count_samples(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (sample_valid === 1'b1) n++;
    end
  endtask : count_samples

  task automatic led_hi(output int n);
    n = 0;
    while (assoc_led !== 1'b0) @(posedge pclk);
    while (assoc_led !== 1'b1) @(posedge pclk);
    while (assoc_led === 1'b1) begin
      n++;
      @(posedge pclk);
    end
  endtask : led_hi

  task automatic signal_strength_pwm_high(output int n);
    n = 0;
    repeat (1024) begin
      @(posedge pclk);
      n += (signal_strength_pwm === 1'b1);
    end
  endtask : signal_strength_pwm_high

  task automatic t_regs;
    chk("pull_en_rst", 32'h7fff, {17'h0, pull_en});
    rd("pull_dir_rst", iolcs_pkg::OFS_PULL_DIR, 32'h0);
    rd("pwm_a_rst", iolcs_pkg::OFS_PWM_A, 32'h0);
    rd("pwm_b_rst", iolcs_pkg::OFS_PWM_B, 32'h0);
    rd("signal_strength_pwm_rst", iolcs_pkg::OFS_SIGNAL_STRENGTH_PWM_TMR, 32'h28);
    rd("rate_rst", iolcs_pkg::OFS_SLEEP_RATE, 32'h1);
    chk("aref_rst", 32'h0, {31'h0, analog_ref_hi});
    wr(iolcs_pkg::OFS_AREF, 32'h1);
    #1;
    chk("aref_hi", 32'h1, {31'h0, analog_ref_hi});
    rd("unmapped", 8'h3c, 32'h0);
    wr(iolcs_pkg::OFS_TEMP, 32'h0);
    rd("temp", iolcs_pkg::OFS_TEMP, 32'hffff_fff6);
    rd("supply", iolcs_pkg::OFS_SUPPLY, 32'h0ce4);
  endtask : t_regs

  task automatic t_pull;
    wr(iolcs_pkg::OFS_PULL_EN, 32'h4005);
    wr(iolcs_pkg::OFS_PULL_DIR, 32'h1);
    #1;
    chk("pull_en", 32'h4005, {17'h0, pull_en});
    chk("pull_up", 32'h1, {31'h0, pull_up[0] & ~pull_up[2]});
    // bit 0 is dio4, bit 14 the serial output line dio13
    @(posedge pclk);
    line_func[4] <= iolcs_pkg::FUNC_DOUT_LO;
    line_func[13] <= iolcs_pkg::FUNC_ALT;
    @(posedge pclk);
    #1;
    chk("pull_ignored", 32'h0004, {17'h0, pull_en});
    @(posedge pclk);
    line_func <= {15{iolcs_pkg::FUNC_DIN}};
  endtask : t_pull

  task automatic t_force;
    for (int m = 0; m < 2; m++) begin
      wr(iolcs_pkg::OFS_CTRL, m);
      wr(iolcs_pkg::OFS_FORCE, 32'h0);
      #1;
      chk("host_ok", m, {31'h0, host_ok});
      @(posedge pclk);
      #1;
      chk("force_valid", 32'h1, {31'h0, sample_valid});
      chk("force_ascii", 1 - m, {31'h0, sample_info.ascii});
      chk("force_dio", {19'h0, dio_pin}, {19'h0, sample_info.dio});
      chk("force_mask", 32'h1fff, {19'h0, sample_info.dio_mask});
    end
  endtask : t_force

  task automatic t_change;
    int n;
    wr(iolcs_pkg::OFS_CHG_MASK, 32'h8);
    dio_pin[3] <= ~dio_pin[3];
    n = 0;
    while (change_pulse !== 1'b1 && n < 8) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("chg_seen", 32'h1, {31'h0, change_pulse});
    @(posedge pclk);
    #1;
    chk("chg_width", 32'h0, {31'h0, change_pulse});
    chk("chg_sample", 32'h1, {31'h0, sample_valid});
    @(posedge pclk);
    dio_pin[4] <= ~dio_pin[4];
    count_samples(12, n);
    chk("chg_unmasked", 32'h0, n);
  endtask : t_change

  task automatic t_pwm;
    int a;
    int b;
    line_func[10] <= iolcs_pkg::FUNC_ADC;
    line_func[11] <= iolcs_pkg::FUNC_ADC;
    wr(iolcs_pkg::OFS_PWM_A, 32'h100);
    wr(iolcs_pkg::OFS_PWM_B, 32'h3ff);
    repeat (1100) @(posedge pclk);
    a = 0;
    b = 0;
    repeat (1024) begin
      @(posedge pclk);
      a += (pwm_a_out === 1'b1);
      b += (pwm_b_out === 1'b1);
    end
    chk("pwm_a_high", 256, a);
    chk("pwm_b_high", 1023, b);
    line_func <= {15{iolcs_pkg::FUNC_DIN}};
  endtask : t_pwm

  task automatic t_periodic;
    int n;
    wr(iolcs_pkg::OFS_INTERVAL, 32'h3);
    while (sample_valid !== 1'b1) @(posedge pclk);
    n = 1;
    @(posedge pclk);
    while (sample_valid !== 1'b1 && n < 200) begin
      n++;
      @(posedge pclk);
    end
    chk("interval", 3 * MSC, n);
    wr(iolcs_pkg::OFS_SLEEP_RATE, 32'h2);
    wake_cycle_start <= 1'b1;
    @(posedge pclk);
    wake_cycle_start <= 1'b0;
    repeat (4) @(posedge pclk);
    count_samples(100, n);
    chk("wake_skip", 32'h0, n);
    wr(iolcs_pkg::OFS_SLEEP_RATE, 32'h1);
    // reopen the window so the later quiet checks are not trivially met
    wake_cycle_start <= 1'b1;
    @(posedge pclk);
    wake_cycle_start <= 1'b0;
    count_samples(100, n);
    chk("wake_open", 32'h1, {31'h0, n >= 3});
    line_func <= {15{iolcs_pkg::FUNC_DISABLED}};
    repeat (4) @(posedge pclk);
    count_samples(100, n);
    chk("no_lines", 32'h0, n);
    line_func <= {15{iolcs_pkg::FUNC_DIN}};
    wr(iolcs_pkg::OFS_INTERVAL, 32'h0);
    repeat (4) @(posedge pclk);
    count_samples(100, n);
    chk("interval_off", 32'h0, n);
  endtask : t_periodic

  task automatic t_signal_strength_pwm;
    int n;
    line_func[10] <= iolcs_pkg::FUNC_ALT;
    wr(iolcs_pkg::OFS_SIGNAL_STRENGTH_PWM_TMR, 32'h3);
    signal_strength_pwm_restart <= 1'b1;
    @(posedge pclk);
    signal_strength_pwm_restart <= 1'b0;
    signal_strength_pwm_high(n);
    chk("signal_strength_pwm_on", 512, n);
    repeat (2500) @(posedge pclk);
    signal_strength_pwm_high(n);
    chk("signal_strength_pwm_expired", 32'h0, n);
    wr(iolcs_pkg::OFS_SIGNAL_STRENGTH_PWM_TMR, 32'hff);
    @(posedge pclk);
    signal_strength_pwm_high(n);
    chk("signal_strength_pwm_always", 512, n);
  endtask : t_signal_strength_pwm

  task automatic t_led;
    int n;
    line_func[5] <= 3'h1;
    wr(iolcs_pkg::OFS_LED_TIME, 32'h14);
    led_hi(n);
    led_hi(n);
    chk("led_set", 20 * 10 * MSC, n);
    wr(iolcs_pkg::OFS_LED_TIME, 32'h0);
    wr(iolcs_pkg::OFS_CTRL, 32'h2);
    led_hi(n);
    led_hi(n);
    chk("led_coord", 250 * MSC, n);
    wr(iolcs_pkg::OFS_CTRL, 32'h0);
    led_hi(n);
    led_hi(n);
    chk("led_node", 125 * MSC, n);
  endtask : t_led

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pull();
    t_force();
    t_change();
    t_pwm();
    t_periodic();
    t_signal_strength_pwm();
    t_led();
    conclude();
  end

  // all scenarios need about 31k cycles at most
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    conclude();
  end
endmodule : iolcs_top_tb_top
